/* File: rtl/sram_cycle_timer.sv */
// down counter that times each phase of a memory cycle
`timescale 1ns/1ps
`default_nettype none
module sram_cycle_timer #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // load and status
   input wire logic i_load,
   input wire logic [W-1:0] i_count,
   output logic o_expired
);
   logic [W-1:0] cnt_ff; // remaining cycles
   logic [W-1:0] nxt_cnt;

   // reload wins over counting so a new phase always gets its full width
   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (i_load)
      begin
         nxt_cnt = i_count;
      end
      else if (cnt_ff != '0)
      begin
         nxt_cnt = cnt_ff - W'(1);
      end
   end

   // counter register
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt_ff <= '0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   // status depends on the count alone; gating it with the load would close a loop
   // through the sequencer, which loads when it sees the expiry in setup and pulse
   assign o_expired = (cnt_ff == '0);
endmodule : sram_cycle_timer
`default_nettype wire

/* File: rtl/sram_host_ctrl.sv */
// host controller driving a 64K x 32 static RAM module with byte selects
// Behaviour
// - write starts both low, ends either rising
// - data held across the terminating rising edge
// - write enables stay high throughout a read
// - address valid before select falls
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_regs.svh"
module sram_host_ctrl #(
   parameter int RD_CYC = `SRAM_RD_CYC,
   parameter int WR_CYC = `SRAM_WR_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // user request side
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [`SRAM_ADDR_W-1:0] i_addr,
   input wire logic [`SRAM_DATA_W-1:0] i_wdata,
   input wire sram_host_pkg::lane_t i_lanes,
   output logic o_ready,
   output logic o_rvalid,
   output logic [`SRAM_DATA_W-1:0] o_rdata,
   // memory pins
   output logic [`SRAM_ADDR_W-1:0] o_mem_addr,
   output logic [`SRAM_LANES-1:0] o_mem_cs_n,
   output logic [`SRAM_HALVES-1:0] o_mem_we_n,
   output logic [`SRAM_DATA_W-1:0] o_mem_dq,
   output logic [`SRAM_DATA_W-1:0] o_mem_dq_oe,
   input wire logic [`SRAM_DATA_W-1:0] i_mem_dq
);
   import sram_host_pkg::*;

   localparam int TW = 4;

   // a write enable half is pulsed if either of its lanes is selected
   function automatic logic [`SRAM_HALVES-1:0] halves_of(input lane_t ln);
      halves_of = {ln[3] | ln[2], ln[1] | ln[0]};
   endfunction : halves_of

   phase_e st_ff, nxt_st; // cycle phase
   logic wr_ff, nxt_wr; // current cycle is a write
   logic [`SRAM_ADDR_W-1:0] addr_ff, nxt_addr; // latched address
   logic [`SRAM_DATA_W-1:0] wdat_ff, nxt_wdat; // latched write data
   lane_t lanes_ff, nxt_lanes; // latched lane selects
   logic [`SRAM_LANES-1:0] cs_n_ff, nxt_cs_n; // select pins
   logic [`SRAM_HALVES-1:0] we_n_ff, nxt_we_n; // write enable pins
   logic [`SRAM_DATA_W-1:0] oe_ff, nxt_oe; // data drive enables
   logic ready_ff, nxt_ready;
   logic rvalid_ff, nxt_rvalid;
   logic [`SRAM_DATA_W-1:0] rdata_ff, nxt_rdata;
   logic [`SRAM_DATA_W-1:0] dq_s1_ff, dq_s2_ff; // read data synchroniser
   logic tmr_load; // restart phase timer
   logic [TW-1:0] tmr_count;
   logic tmr_done;

   // phase timer shared by setup, pulse and hold
   sram_cycle_timer #(.W(TW)) u_timer (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_load(tmr_load),
      .i_count(tmr_count),
      .o_expired(tmr_done)
   );

   // cycle sequencer; selects and enables only change at phase edges
   always_comb
   begin
      nxt_st = st_ff;
      nxt_wr = wr_ff;
      nxt_addr = addr_ff;
      nxt_wdat = wdat_ff;
      nxt_lanes = lanes_ff;
      nxt_cs_n = cs_n_ff;
      nxt_we_n = we_n_ff;
      nxt_oe = oe_ff;
      nxt_ready = 1'b0;
      nxt_rvalid = 1'b0;
      nxt_rdata = rdata_ff;
      tmr_load = 1'b0;
      tmr_count = '0;
      unique case (st_ff)
         ST_IDLE:
         begin
            // everything deselected, bus released
            nxt_cs_n = '1;
            nxt_we_n = '1;
            nxt_oe = '0;
            nxt_ready = 1'b1;
            if (i_req && ready_ff && (i_lanes != '0))
            begin
               // address goes out first, selects follow next phase
               nxt_addr = i_addr;
               nxt_wdat = i_wdata;
               nxt_wr = i_wr;
               nxt_lanes = i_lanes;
               nxt_ready = 1'b0;
               nxt_st = ST_SETUP;
               tmr_load = 1'b1;
               tmr_count = TW'(`SRAM_SU_CYC - 1);
            end
         end
         ST_SETUP:
         begin
            if (tmr_done)
            begin
               // one select per chosen lane
               nxt_cs_n = ~lanes_ff;
               if (wr_ff)
               begin
                  // both low opens the write interval
                  nxt_we_n = ~halves_of(lanes_ff);
                  for (int b = 0; b < `SRAM_LANES; b++)
                  begin
                     nxt_oe[b*8 +: 8] = {8{lanes_ff[b]}};
                  end
                  tmr_count = TW'(WR_CYC - 1);
               end
               else
               begin
                  // enables high for the whole read, module drives
                  nxt_we_n = '1;
                  nxt_oe = '0;
                  // two extra cycles so the sampled word has cleared both sync flops
                  tmr_count = TW'(RD_CYC + 1);
               end
               tmr_load = 1'b1;
               nxt_st = ST_PULSE;
            end
         end
         ST_PULSE:
         begin
            if (tmr_done)
            begin
               // enable rises first; on a write select and data stay one more cycle, on a read the selects rise here too
               nxt_we_n = '1;
               if (!wr_ff)
               begin
                  nxt_cs_n = '1;
                  for (int b = 0; b < `SRAM_LANES; b++)
                  begin
                     if (lanes_ff[b])
                     begin
                        nxt_rdata[b*8 +: 8] = dq_s2_ff[b*8 +: 8];
                     end
                  end
               end
               tmr_load = 1'b1;
               tmr_count = TW'(`SRAM_HD_CYC - 1);
               nxt_st = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            if (tmr_done)
            begin
               // data released only after the terminating edge
               nxt_cs_n = '1;
               nxt_oe = '0;
               nxt_rvalid = !wr_ff;
               nxt_st = ST_DONE;
            end
         end
         ST_DONE:
         begin
            nxt_st = ST_IDLE;
         end
         default:
         begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   // pin and status registers
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st_ff <= ST_IDLE;
         wr_ff <= 1'b0;
         addr_ff <= '0;
         wdat_ff <= '0;
         lanes_ff <= '0;
         cs_n_ff <= '1;
         we_n_ff <= '1;
         oe_ff <= '0;
         ready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
         wr_ff <= nxt_wr;
         addr_ff <= nxt_addr;
         wdat_ff <= nxt_wdat;
         lanes_ff <= nxt_lanes;
         cs_n_ff <= nxt_cs_n;
         we_n_ff <= nxt_we_n;
         oe_ff <= nxt_oe;
         ready_ff <= nxt_ready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
      end
   end

   // read data arrives from pins, so two flops before use
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         dq_s1_ff <= '0;
         dq_s2_ff <= '0;
      end
      else
      begin
         dq_s1_ff <= i_mem_dq;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   assign o_ready = ready_ff;
   assign o_rvalid = rvalid_ff;
   assign o_rdata = rdata_ff;
   assign o_mem_addr = addr_ff;
   assign o_mem_cs_n = cs_n_ff;
   assign o_mem_we_n = we_n_ff;
   assign o_mem_dq = wdat_ff;
   assign o_mem_dq_oe = oe_ff;
endmodule : sram_host_ctrl
`default_nettype wire

/* File: rtl/sram_host_pkg.sv */
// types shared by the static RAM host controller
package sram_host_pkg;
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_PULSE = 3'b010,
      ST_HOLD  = 3'b011,
      ST_DONE  = 3'b100
   } phase_e;
   typedef logic [3:0] lane_t;
endpackage : sram_host_pkg

/* File: rtl/sram_host_regs.svh */
// timing constants and pin layout for the 64K x 32 static RAM host controller
`ifndef SRAM_HOST_REGS_SVH
`define SRAM_HOST_REGS_SVH
`define SRAM_ADDR_W 16
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define SRAM_HALVES 2
`define SRAM_CLK_NS 50
`define SRAM_T_RC_NS 55
`define SRAM_T_PWE_NS 40
`define SRAM_T_SA_NS 2
`define SRAM_T_HA_NS 2
`define SRAM_RD_CYC ((`SRAM_T_RC_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
`define SRAM_WR_CYC ((`SRAM_T_PWE_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
`define SRAM_SU_CYC ((`SRAM_T_SA_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
`define SRAM_HD_CYC ((`SRAM_T_HA_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
`endif

/* File: sim/sram_host_monitor.sv */
// pin-level checker for the static RAM host controller
`timescale 1ns/1ps
`default_nettype none
module sram_host_monitor #(parameter int WR_CYC = 1) (
   // request side
   input wire logic i_clk_sys, i_resetn, i_req, i_wr, o_ready, o_rvalid,
   input wire sram_host_pkg::lane_t i_lanes,
   // memory pins
   input wire logic [15:0] o_mem_addr,
   input wire logic [3:0] o_mem_cs_n,
   input wire logic [1:0] o_mem_we_n,
   input wire logic [31:0] o_mem_dq, o_mem_dq_oe
);
   import sram_host_pkg::*;
   logic take; // request accepted this edge
   logic [3:0] we_cnt_ff, nxt_we_cnt; // cycles with an enable low
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   assign take = i_req && o_ready && |i_lanes;
   // restarts whenever both enables are high again
   always_comb nxt_we_cnt = &o_mem_we_n ? 4'h0 : we_cnt_ff + 4'h1;
   always_ff @(posedge i_clk_sys or negedge i_resetn)
      if (!i_resetn)
         we_cnt_ff <= 4'h0;
      else
         we_cnt_ff <= nxt_we_cnt;
   a_lane_select: assert property (
      take |-> ##3 o_mem_cs_n == ~$past(i_lanes, 3)) else $error("lane select wrong");
   a_half_enable: assert property (
      take && i_wr |-> ##2 o_mem_we_n == ~{|$past(i_lanes[3:2], 2), |$past(i_lanes[1:0], 2)})
      else $error("half enable wrong");
   a_read_quiet: assert property (
      take && !i_wr |-> ##1 (o_mem_we_n == 2'h3 && o_mem_dq_oe == 32'h0)[*7])
      else $error("read not quiet");
   a_idle_float: assert property (
      &o_mem_cs_n |-> o_mem_dq_oe == 32'h0) else $error("driving while deselected");
   a_we_width: assert property (
      $rose(&o_mem_we_n) |-> we_cnt_ff == WR_CYC) else $error("enable width wrong");
   a_data_hold: assert property (
      $rose(&o_mem_we_n) |-> $stable(o_mem_dq) && $stable(o_mem_dq_oe))
      else $error("data moved at write end");
   a_no_joint_rise: assert property (
      $rose(&o_mem_we_n) |-> $stable(o_mem_cs_n) && o_mem_cs_n != 4'hF)
      else $error("select rose with enable");
   a_addr_steady: assert property (
      !(&o_mem_cs_n) |-> $stable(o_mem_addr)) else $error("address moved while selected");
   a_read_answer: assert property (
      take && !i_wr |-> ##1 !o_rvalid [*6] ##1 o_rvalid) else $error("read answer late");
   c_write: cover property (take && i_wr);
   c_part_read: cover property (take && !i_wr && i_lanes != 4'hF);
   c_write_end: cover property ($rose(&o_mem_we_n));
endmodule : sram_host_monitor
bind sram_host_ctrl sram_host_monitor #(.WR_CYC(WR_CYC)) u_monitor (.i_clk_sys, .i_resetn,
   .i_req, .i_wr, .o_ready, .o_rvalid, .i_lanes, .o_mem_addr, .o_mem_cs_n, .o_mem_we_n,
   .o_mem_dq, .o_mem_dq_oe);
`default_nettype wire

/* File: sim/sram_module_model.sv */
// behavioural 64K x 32 static RAM module with byte selects
`timescale 1ns/1ps
`default_nettype none
module sram_module_model (
   // pins from the host
   input wire logic [15:0] i_addr,
   input wire logic [3:0] i_cs_n,
   input wire logic [1:0] i_we_n,
   input wire logic [31:0] i_dq,
   // drive back onto the data wire
   output logic [31:0] o_dq,
   output logic [31:0] o_oe
);
   logic [7:0] mem [int]; // sparse store, byte per key
   logic [3:0] wr_on, was_on = 4'h0;
   logic [31:0] last = 32'h0; // last bytes driven
   // lane writes while its select and its half's enable are both low
   assign wr_on = ~i_cs_n & ~{i_we_n[1], i_we_n[1], i_we_n[0], i_we_n[0]};
   // byte taken on whichever rising edge closes the interval
   always @(wr_on)
   begin
      for (int b = 0; b < 4; b++)
         if (was_on[b] && !wr_on[b])
            mem[{i_addr, b[1:0]}] = i_dq[8*b +: 8];
      was_on = wr_on;
   end
   // floating lanes show inverted leftovers so a stale sample cannot match
   always @*
      for (int b = 0; b < 4; b++)
      begin
         o_oe[8*b +: 8] = {8{!i_cs_n[b] && i_we_n[b/2]}};
         if (o_oe[8*b])
         begin
            o_dq[8*b +: 8] = mem[{i_addr, b[1:0]}];
            last[8*b +: 8] = o_dq[8*b +: 8];
         end
         else
            o_dq[8*b +: 8] = ~last[8*b +: 8];
      end
endmodule : sram_module_model
`default_nettype wire

/* File: sim/tb_sram_host_ctrl.sv */
// self-checking bench for the static RAM host controller
`timescale 1ns/1ps
`default_nettype none
module tb_sram_host_ctrl;
   logic i_clk_sys, i_resetn, i_req, i_wr, o_ready, o_rvalid;
   logic [15:0] i_addr, o_mem_addr;
   logic [31:0] i_wdata, o_rdata, o_mem_dq, o_mem_dq_oe, i_mem_dq, m_dq, r, exp_rd;
   logic [3:0] i_lanes, o_mem_cs_n;
   logic [1:0] o_mem_we_n;
   logic [31:0] seed = 32'h7A058C02;
   logic [15:0] addr_tab [4] = '{16'h0000, 16'hFFFF, 16'h00A0, 16'h5A5A};
   logic [7:0] shadow [int]; // expected memory contents
   logic [31:0] exp_q [$]; // expected read answers, oldest first
   int fail_count = 0;
   int check_count = 0;
   // host drive wins where enabled, else the module side
   assign i_mem_dq = (o_mem_dq & o_mem_dq_oe) | (m_dq & ~o_mem_dq_oe);
   sram_host_ctrl #(.RD_CYC(2), .WR_CYC(1)) u_dut (.i_clk_sys, .i_resetn, .i_req, .i_wr,
      .i_addr, .i_wdata, .i_lanes, .o_ready, .o_rvalid, .o_rdata, .o_mem_addr, .o_mem_cs_n,
      .o_mem_we_n, .o_mem_dq, .o_mem_dq_oe, .i_mem_dq);
   sram_module_model u_mem (.i_addr(o_mem_addr), .i_cs_n(o_mem_cs_n), .i_we_n(o_mem_we_n),
      .i_dq(i_mem_dq), .o_dq(m_dq), .o_oe());
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // one request; shadow and expected read word follow the lane mask
   task automatic op(input logic w, input logic [15:0] a, input logic [31:0] d,
      input logic [3:0] m);
      int n = 0;
      while (o_ready !== 1'b1 && n < 40)
      begin
         @(negedge i_clk_sys);
         n++;
      end
      i_req = 1'b1;
      i_wr = w;
      i_addr = a;
      i_wdata = d;
      i_lanes = m;
      @(negedge i_clk_sys);
      i_req = 1'b0;
      for (int b = 0; b < 4; b++)
         if (m[b] && w)
            shadow[{a, b[1:0]}] = d[8*b +: 8];
         else if (m[b])
            exp_rd[8*b +: 8] = shadow[{a, b[1:0]}];
      if (!w && m != 4'h0)
         exp_q.push_back(exp_rd);
   endtask : op
   task results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   initial
   begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // about 800 cycles of traffic; five times that means a hang
   initial
   begin
      #200_000;
      fail_count++;
      results();
   end
   // read answers stand one cycle
   always @(negedge i_clk_sys)
      if (o_rvalid === 1'b1)
         cmp(o_rdata, exp_q.pop_front());
   initial
   begin
      {i_resetn, i_req, i_wr, i_addr, i_wdata, i_lanes} = '0;
      exp_rd = 32'h0;
      repeat (8) @(negedge i_clk_sys);
      cmp({o_ready, o_mem_cs_n, o_mem_we_n, |o_mem_dq_oe}, 32'h7E);
      i_resetn = 1'b1;
      @(negedge i_clk_sys);
      for (int i = 0; i < 4; i++)
         op(1'b1, addr_tab[i], rnd(), 4'hF);
      for (int i = 0; i < 4; i++)
         op(1'b0, addr_tab[i], rnd(), 4'hF);
      $display("test corners done");
      for (int m = 1; m < 16; m++)
      begin
         op(1'b1, 16'h00A0, rnd(), m[3:0]);
         op(1'b0, 16'h00A0, rnd(), m[3:0]);
         op(1'b0, 16'h00A0, rnd(), 4'hF);
      end
      $display("test lanes done");
      op(1'b1, 16'h00A0, rnd(), 4'h0);
      repeat (6) @(negedge i_clk_sys);
      cmp({o_ready, o_mem_cs_n}, 32'h1F);
      op(1'b0, 16'h00A0, rnd(), 4'hF);
      $display("test refused done");
      for (int i = 0; i < 40; i++)
      begin
         r = rnd();
         op(r[4], addr_tab[r[6:5]], rnd(), (r[3:0] == 4'h0) ? 4'h6 : r[3:0]);
      end
      repeat (12) @(negedge i_clk_sys);
      cmp(exp_q.size(), 0);
      $display("test random done");
      results();
   end
endmodule : tb_sram_host_ctrl
`default_nettype wire
